// ==== src/row_repair_ctrl.sv ====
// Soft row repair engine of the memory device with its register slave
`timescale 1ns/1ps

// Overview of operation
// - Mode register four bit 5 enables soft repair; bit 13 enables hard repair.
// - Soft repair entry needs the four guard keys after the enable.
// - First ACT after entry latches bank group, bank and row as seed.
// - Soft repairs persist until reset or a later repair of that bank.
// - One soft repaired row per bank; a new one replaces it.
// - Banks without repair resource discard the sequence.
// - Seed row and rows differing in A17..A13, A1, A0 lose data.
// - Writing the soft enable holds all DQ high.
// - Wrong key order or another MR command voids entry; ACT and WR act normally.
// - Keys have BG=BA=0, A6:0 all ones, A11..A7 11001,01111,10111,00111.
// - Repair only if all DQ low for all eight beats from write latency.
// - Readout page 2 location 0 shows hard (beat 0) and soft (beat 1) availability.
module row_repair_ctrl (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Memory command pins
    input  wire logic        ck_i,
    input  wire logic        cs_n_i,
    input  wire logic        act_n_i,
    input  wire logic [1:0]  bg_i,
    input  wire logic [1:0]  ba_i,
    input  wire logic [17:0] addr_i,
    // Data pins
    input  wire logic [7:0]  dq_i,
    output logic [7:0]       dq_o,
    output logic             dq_oe_o,
    // Status
    output logic             soft_mode_o,
    output logic             repair_hit_o,
    output logic             assoc_hit_o
);

    typedef struct packed {
        ppr_pkg::state_e     st;
        logic                hard_en;
        logic [5:0]          lat;
        logic [5:0]          lat_cnt;
        logic [3:0]          beat;
        logic                dq_fail;
        logic [3:0]          sbank;
        logic [17:0]         srow;
        logic [15:0]         valid;
        logic [15:0][17:0]   rows;
        logic [15:0]         hard_avl;
        logic                soft_sup;
        logic                mpr_on;
        logic [1:0]          mpr_page;
        logic                mpr_act;
        logic [5:0]          mpr_cnt;
        logic [3:0]          mpr_beat;
        logic [7:0]          mpr_byte;
        logic [2:0]          wait_cnt;
        logic                recog;
        logic [4:0]          sticky;
        logic                ack;
        logic [31:0]         rdat;
        logic [7:0]          dq;
        logic                dq_oe;
        logic                hit;
        logic                assoc;
    } core_s;

    core_s          s_ff;
    core_s          nxt_s;
    ppr_pkg::pins_s pin_raw;
    ppr_pkg::pins_s pin;
    ppr_pkg::stat_s stat;
    logic           ck_rise;
    logic           ck_fall;
    logic           is_cmd;
    logic           is_act;
    logic           is_mrs;
    logic           is_other;
    logic [2:0]     rcw;
    logic [2:0]     mr_sel;
    logic [3:0]     bank;
    logic           key_start;
    logic           key_done;
    logic           key_fail;
    logic           wb_acc;

    // ****************************************
    // Pin capture and command decode
    // ****************************************
    assign pin_raw = '{cs_n: cs_n_i, act_n: act_n_i, bg: bg_i, ba: ba_i, addr: addr_i, dq: dq_i};

    pin_sync #(
        .W ($bits(ppr_pkg::pins_s))
    ) u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ck_i   (ck_i),
        .pins_i (pin_raw),
        .pins_o (pin),
        .rise_o (ck_rise),
        .fall_o (ck_fall)
    );

    // Commands are taken at the rising edge of the link clock
    assign is_cmd   = ck_rise & ~pin.cs_n;
    assign is_act   = is_cmd & ~pin.act_n;
    assign rcw      = pin.addr[16:14];
    assign is_mrs   = is_cmd & pin.act_n & (rcw == ppr_pkg::CMD_MRS);
    assign is_other = is_cmd & ~is_mrs;
    assign mr_sel   = {pin.bg[0], pin.ba};
    assign bank     = {pin.bg, pin.ba};
    assign wb_acc   = wb_cyc_i & wb_stb_i & ~s_ff.ack;

    guard_key_seq u_keys (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (key_start),
        .active_i (s_ff.st == ppr_pkg::ST_KEYS),
        .mrs_i    (is_mrs),
        .other_i  (is_other),
        .mr_sel_i (mr_sel),
        .addr_i   (pin.addr),
        .done_o   (key_done),
        .fail_o   (key_fail)
    );

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign stat = '{st: s_ff.st, hard_en: s_ff.hard_en, soft_en: s_ff.st != ppr_pkg::ST_IDLE,
                    recog: s_ff.recog, discard: s_ff.sticky[4], commit: s_ff.sticky[3],
                    err_both: s_ff.sticky[2], err_cmd: s_ff.sticky[1], err_ref: s_ff.sticky[0]};

    // ****************************************
    // Repair sequencer
    // ****************************************
    always_comb begin
        logic        samp;
        logic        msamp;
        logic [4:0]  set;
        logic [31:0] ctrl;
        samp      = 1'b0;
        msamp     = 1'b0;
        set       = '0;
        ctrl      = '0;
        key_start = 1'b0;
        nxt_s     = s_ff;

        // Mode register writes: enables and readout page
        if (is_mrs && mr_sel == ppr_pkg::MR_SEL_FOUR) begin
            nxt_s.hard_en = pin.addr[ppr_pkg::MR4_HARD_BIT];
            if (!pin.addr[ppr_pkg::MR4_SOFT_BIT]) begin
                nxt_s.st    = ppr_pkg::ST_IDLE;
                nxt_s.dq_oe = 1'b0;
            end else if (s_ff.st == ppr_pkg::ST_IDLE) begin
                nxt_s.st    = ppr_pkg::ST_KEYS;
                nxt_s.recog = 1'b0;
                key_start   = 1'b1;
                nxt_s.dq    = '1;
                nxt_s.dq_oe = 1'b1;
            end
        end
        if (is_mrs && mr_sel == ppr_pkg::MR_SEL_THREE) begin
            nxt_s.mpr_on   = pin.addr[ppr_pkg::MR3_MPR_BIT];
            nxt_s.mpr_page = pin.addr[1:0];
        end

        // Protocol misuse seen by the device
        if (is_cmd && rcw == ppr_pkg::CMD_REF && pin.act_n && s_ff.st != ppr_pkg::ST_IDLE) begin
            set[0] = 1'b1;
        end
        if (s_ff.hard_en && s_ff.st != ppr_pkg::ST_IDLE) begin
            set[2] = 1'b1;
        end

        case (s_ff.st)
            ppr_pkg::ST_KEYS: begin
                if (key_done) begin
                    nxt_s.st    = ppr_pkg::ST_ARMED;
                    nxt_s.dq_oe = 1'b0;
                end else if (key_fail && nxt_s.st == ppr_pkg::ST_KEYS) begin
                    nxt_s.st    = ppr_pkg::ST_VOID;
                    nxt_s.dq_oe = 1'b0;
                end
            end
            ppr_pkg::ST_ARMED: begin
                if (is_act) begin
                    nxt_s.sbank = bank;
                    nxt_s.srow  = pin.addr;
                    nxt_s.st    = ppr_pkg::ST_SEED;
                end else if (is_other) begin
                    set[1] = 1'b1;
                end
            end
            ppr_pkg::ST_SEED: begin
                if (is_cmd && pin.act_n && rcw == ppr_pkg::CMD_WR && bank == s_ff.sbank) begin
                    nxt_s.st      = ppr_pkg::ST_BURST;
                    nxt_s.lat_cnt = s_ff.lat;
                    nxt_s.beat    = '0;
                    nxt_s.dq_fail = 1'b0;
                end else if (is_other) begin
                    set[1] = 1'b1;
                end
            end
            ppr_pkg::ST_BURST: begin
                if (ck_rise && s_ff.lat_cnt != '0) begin
                    nxt_s.lat_cnt = s_ff.lat_cnt - 6'h1;
                end
                samp = (ck_rise && s_ff.lat_cnt == 6'h1) || ((ck_rise || ck_fall) && s_ff.lat_cnt == '0);
                if (samp) begin
                    nxt_s.dq_fail = s_ff.dq_fail | (|pin.dq);
                    nxt_s.beat    = s_ff.beat + 4'h1;
                    if (s_ff.beat + 4'h1 == ppr_pkg::BURST_BEATS) begin
                        nxt_s.st = ppr_pkg::ST_RECOG;
                        if (!nxt_s.dq_fail) begin
                            if (s_ff.hard_avl[s_ff.sbank] && s_ff.soft_sup) begin
                                nxt_s.valid[s_ff.sbank] = 1'b1;
                                nxt_s.rows[s_ff.sbank]  = s_ff.srow;
                                set[3] = 1'b1;
                            end else begin
                                set[4] = 1'b1;
                            end
                        end
                    end
                end
            end
            ppr_pkg::ST_RECOG: begin
                if (is_cmd && pin.act_n && rcw == ppr_pkg::CMD_PRE) begin
                    nxt_s.wait_cnt = ppr_pkg::WAIT_INIT;
                end else if (s_ff.wait_cnt != '0) begin
                    nxt_s.wait_cnt = s_ff.wait_cnt - 3'h1;
                    nxt_s.recog    = s_ff.wait_cnt == 3'h1;
                end
            end
            default: begin
            end
        endcase

        // Normal activates: report hits on repaired rows and their neighbours
        if (is_act && (s_ff.st == ppr_pkg::ST_IDLE || s_ff.st == ppr_pkg::ST_VOID)) begin
            nxt_s.hit   = s_ff.valid[bank] && pin.addr == s_ff.rows[bank];
            nxt_s.assoc = s_ff.valid[bank] && pin.addr != s_ff.rows[bank]
                       && ((pin.addr ^ s_ff.rows[bank]) & ~ppr_pkg::ASSOC_MASK) == '0;
        end

        // Availability readout, MSB first on all lanes
        if (is_cmd && pin.act_n && rcw == ppr_pkg::CMD_RD && s_ff.mpr_on && !s_ff.mpr_act
            && s_ff.mpr_page == ppr_pkg::MPR_PAGE_ID && pin.ba == ppr_pkg::MPR_LOC_ID) begin
            nxt_s.mpr_act  = 1'b1;
            nxt_s.mpr_cnt  = s_ff.lat;
            nxt_s.mpr_beat = '0;
            nxt_s.mpr_byte = {|s_ff.hard_avl, s_ff.soft_sup & (|s_ff.hard_avl), 6'h0};
        end else if (s_ff.mpr_act) begin
            if (ck_rise && s_ff.mpr_cnt != '0) begin
                nxt_s.mpr_cnt = s_ff.mpr_cnt - 6'h1;
            end
            msamp = (ck_rise && s_ff.mpr_cnt == 6'h1) || ((ck_rise || ck_fall) && s_ff.mpr_cnt == '0);
            if (msamp) begin
                if (s_ff.mpr_beat == ppr_pkg::BURST_BEATS) begin
                    nxt_s.mpr_act = 1'b0;
                    nxt_s.dq_oe   = 1'b0;
                end else begin
                    nxt_s.dq       = {8{s_ff.mpr_byte[7]}};
                    nxt_s.dq_oe    = 1'b1;
                    nxt_s.mpr_byte = {s_ff.mpr_byte[6:0], 1'b0};
                    nxt_s.mpr_beat = s_ff.mpr_beat + 4'h1;
                end
            end
        end

        // Register slave: one-cycle ack, unmapped reads zero
        nxt_s.ack = wb_acc;
        if (wb_acc) begin
            ctrl = 32'({s_ff.soft_sup, 2'h0, s_ff.lat});
            case (wb_adr_i)
                ppr_pkg::REG_CTRL:     nxt_s.rdat = ctrl;
                ppr_pkg::REG_HARD_AVL: nxt_s.rdat = 32'(s_ff.hard_avl);
                ppr_pkg::REG_STATUS:   nxt_s.rdat = 32'(stat);
                ppr_pkg::REG_SOFT_VLD: nxt_s.rdat = 32'(s_ff.valid);
                default:               nxt_s.rdat = '0;
            endcase
            if (wb_we_i) begin
                ctrl = merge(ctrl, wb_dat_i, wb_sel_i);
                case (wb_adr_i)
                    ppr_pkg::REG_CTRL: begin
                        nxt_s.lat      = ctrl[ppr_pkg::CTRL_LAT_W-1:0];
                        nxt_s.soft_sup = ctrl[ppr_pkg::CTRL_SUP_BIT];
                    end
                    ppr_pkg::REG_HARD_AVL: begin
                        nxt_s.hard_avl = 16'(merge(32'(s_ff.hard_avl), wb_dat_i, wb_sel_i));
                    end
                    ppr_pkg::REG_STATUS: begin
                        if (wb_sel_i[0]) begin
                            nxt_s.sticky = s_ff.sticky & ~wb_dat_i[ppr_pkg::STICKY_W-1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // Events win over a same-cycle clear
        nxt_s.sticky = nxt_s.sticky | set;
    end

    // Reset wipes every soft repair
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff          <= '0;
            s_ff.st       <= ppr_pkg::ST_IDLE;
            s_ff.lat      <= ppr_pkg::LAT_RST;
            s_ff.hard_avl <= ppr_pkg::HARD_AVL_RST;
            s_ff.soft_sup <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_dat_o     = s_ff.rdat;
    assign wb_ack_o     = s_ff.ack;
    assign dq_o         = s_ff.dq;
    assign dq_oe_o      = s_ff.dq_oe;
    assign soft_mode_o  = s_ff.st != ppr_pkg::ST_IDLE;
    assign repair_hit_o = s_ff.hit;
    assign assoc_hit_o  = s_ff.assoc;

endmodule

// ==== src/ppr_pkg.sv ====
// Shared constants, register map and carrier types of the row repair block
package ppr_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_PS         = 4000;
    localparam int SOFT_PRECH_WAIT_NS    = 20;
    localparam int SOFT_PRECH_WAIT_CYC   = (SOFT_PRECH_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HARD_PGM_X8_MS        = 1000;
    localparam int HARD_PGM_X16_MS       = 2000;
    localparam int HARD_PRECH_WAIT_NS    = 15;
    localparam int HARD_PRECH_WAIT_CYC   = (HARD_PRECH_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HARD_EXIT_WAIT_US     = 50;
    localparam logic [2:0] WAIT_INIT     = 3'(SOFT_PRECH_WAIT_CYC);

    // ****************************************
    // Command decoding
    // ****************************************
    localparam logic [2:0] CMD_MRS       = 3'h0;
    localparam logic [2:0] CMD_REF       = 3'h1;
    localparam logic [2:0] CMD_PRE       = 3'h2;
    localparam logic [2:0] CMD_WR        = 3'h4;
    localparam logic [2:0] CMD_RD        = 3'h5;
    localparam logic [2:0] MR_SEL_ZERO   = 3'h0;
    localparam logic [2:0] MR_SEL_THREE  = 3'h3;
    localparam logic [2:0] MR_SEL_FOUR   = 3'h4;
    localparam int MR4_SOFT_BIT          = 5;
    localparam int MR4_HARD_BIT          = 13;
    localparam int MR3_MPR_BIT           = 2;
    localparam logic [1:0] MPR_PAGE_ID   = 2'h2;
    localparam logic [1:0] MPR_LOC_ID    = 2'h0;
    localparam logic [6:0] KEY_LOW_ONES  = 7'h7f;
    // Guard keys on A11..A7, entry 0 first
    localparam logic [3:0][4:0] GUARD_KEYS = {5'h07, 5'h17, 5'h0f, 5'h19};
    localparam logic [2:0] KEY_COUNT     = 3'h4;
    localparam logic [3:0] BURST_BEATS   = 4'h8;
    // Row bits whose neighbours lose data: A17..A13, A1, A0
    localparam logic [17:0] ASSOC_MASK   = 18'h3e003;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_HARD_AVL  = 8'h04;
    localparam logic [7:0] REG_STATUS    = 8'h08;
    localparam logic [7:0] REG_SOFT_VLD  = 8'h0c;
    localparam int CTRL_LAT_W            = 6;
    localparam int CTRL_SUP_BIT          = 8;
    localparam logic [5:0] LAT_RST       = 6'h0b;
    localparam logic [15:0] HARD_AVL_RST = 16'hffff;
    localparam int STICKY_W              = 5;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_KEYS  = 7'h02,
        ST_ARMED = 7'h04,
        ST_SEED  = 7'h08,
        ST_BURST = 7'h10,
        ST_RECOG = 7'h20,
        ST_VOID  = 7'h40
    } state_e;

    typedef struct packed {
        logic        cs_n;
        logic        act_n;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [17:0] addr;
        logic [7:0]  dq;
    } pins_s;

    typedef struct packed {
        state_e     st;
        logic       hard_en;
        logic       soft_en;
        logic       recog;
        logic       discard;
        logic       commit;
        logic       err_both;
        logic       err_cmd;
        logic       err_ref;
    } stat_s;

endpackage

// ==== src/pin_sync.sv ====
// Two-stage pin synchroniser with edge detection of the sampled link clock
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Raw pins
    input  wire logic         ck_i,
    input  wire logic [W-1:0] pins_i,
    // Synchronised view
    output logic [W-1:0]      pins_o,
    output logic              rise_o,
    output logic              fall_o
);

    typedef struct packed {
        logic [W-1:0] p1;
        logic [W-1:0] p2;
        logic         ck1;
        logic         ck2;
        logic         ck3;
    } sync_s;

    sync_s s_ff;
    sync_s nxt_s;

    // ****************************************
    // Sampling
    // ****************************************
    // First stage feeds only the second stage
    always_comb begin
        nxt_s     = s_ff;
        nxt_s.p1  = pins_i;
        nxt_s.p2  = s_ff.p1;
        nxt_s.ck1 = ck_i;
        nxt_s.ck2 = s_ff.ck1;
        nxt_s.ck3 = s_ff.ck2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Pins and clock share the same delay, so edges line up with data
    assign pins_o = s_ff.p2;
    assign rise_o = s_ff.ck2 & ~s_ff.ck3;
    assign fall_o = ~s_ff.ck2 & s_ff.ck3;

endmodule

// ==== src/guard_key_seq.sv ====
// Checker of the four mode-register guard keys that qualify repair entry
`timescale 1ns/1ps
module guard_key_seq (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Sequence control
    input  wire logic        start_i,
    input  wire logic        active_i,
    // Decoded commands
    input  wire logic        mrs_i,
    input  wire logic        other_i,
    input  wire logic [2:0]  mr_sel_i,
    input  wire logic [17:0] addr_i,
    // Result
    output logic             done_o,
    output logic             fail_o
);

    typedef struct packed {
        logic [2:0] cnt;
        logic       done;
        logic       fail;
    } key_s;

    key_s s_ff;
    key_s nxt_s;
    logic key_ok;

    // ****************************************
    // Key matching
    // ****************************************
    // BG0/BA are folded into mr_sel; BG1 and A17:12 are ignored
    assign key_ok = (mr_sel_i == ppr_pkg::MR_SEL_ZERO)
                 && (addr_i[6:0] == ppr_pkg::KEY_LOW_ONES)
                 && (addr_i[11:7] == ppr_pkg::GUARD_KEYS[s_ff.cnt[1:0]]);

    always_comb begin
        nxt_s = s_ff;
        if (start_i) begin
            nxt_s = '0;
        end else if (active_i && !s_ff.done && !s_ff.fail) begin
            if (mrs_i && key_ok) begin
                nxt_s.cnt  = s_ff.cnt + 3'h1;
                nxt_s.done = (s_ff.cnt + 3'h1) == ppr_pkg::KEY_COUNT;
            end else if (mrs_i || other_i) begin
                nxt_s.fail = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign done_o = s_ff.done;
    assign fail_o = s_ff.fail;

endmodule

// ==== tb/ppr_properties.sv ====
// Checker of bus and pin relations of the row repair block
`timescale 1ns/1ps
module ppr_checker (
    // Clock, reset and bus
    input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [7:0]  wb_adr_i, dq_o,
    input wire logic [31:0] wb_dat_o,
    // Data enable and status
    input wire logic        dq_oe_o, soft_mode_o, repair_hit_o, assoc_hit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request still waiting, then a one-cycle answer
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
    AST_ACK_ANSWER: assert property (s_req |=> s_ack) else $error("no single ack");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    AST_UNMAPPED:
        assert property (s_req ##0 !wb_we_i && wb_adr_i == 8'h10 |=> wb_dat_o == 32'h0) else $error("unmapped data");
    AST_DQ_HIGH: assert property (soft_mode_o && dq_oe_o |-> dq_o == 8'hff) else $error("dq not high");
    AST_ENTRY_OE: assert property ($rose(soft_mode_o) |-> dq_oe_o) else $error("dq not driven");
    AST_EXIT_OE: assert property ($fell(soft_mode_o) |-> !dq_oe_o) else $error("dq still driven");
    AST_RST_CLEAR: assert property ($fell(rst_i) |->
        !soft_mode_o && !repair_hit_o && !assoc_hit_o) else $error("state kept over reset");
endmodule
bind row_repair_ctrl ppr_checker chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i), .dq_o(dq_o), .wb_dat_o(wb_dat_o),
    .dq_oe_o(dq_oe_o), .soft_mode_o(soft_mode_o), .repair_hit_o(repair_hit_o), .assoc_hit_o(assoc_hit_o));

// ==== tb/mc_model.sv ====
// Memory controller model driving link clock, command and data pins
`timescale 1ns/1ps
module mc_model #(parameter int WL = 11, parameter int GAP = 4) (
    output logic        ck_o, cs_n_o, act_n_o,
    output logic [1:0]  bg_o, ba_o,
    output logic [17:0] addr_o,
    output logic [7:0]  dq_o
);
    // Idle: clock low, deselected; hard repair is never run, so its long waits never arise
    initial {ck_o, cs_n_o, act_n_o, bg_o, ba_o, addr_o, dq_o} = 33'h0c0000000;
    // Link clock, 32 ns; commands change on falling edges
    always #16 ck_o = ~ck_o;
    task automatic cmd(input logic a, input logic [1:0] g, b, input logic [17:0] ad);
        @(negedge ck_o);
        {cs_n_o, act_n_o, bg_o, ba_o, addr_o} <= {1'b0, a, g, b, ad};
        @(negedge ck_o);
        cs_n_o <= 1'b1;
        addr_o <= ~ad; // Deselected lines must not keep the last value
        repeat (GAP) @(negedge ck_o); // Spacing covers key, ACT, WR and PRE waits
    endtask
    // Write, then eight beats centred on the edges from write latency on
    task automatic wr(input logic [1:0] g, b, input logic [63:0] d);
        @(negedge ck_o);
        {cs_n_o, act_n_o, bg_o, ba_o, addr_o} <= {2'b01, g, b, 18'h10000};
        @(posedge ck_o);
        #8 cs_n_o <= 1'b1;
        repeat (WL - 1) @(posedge ck_o);
        #8;
        for (int i = 0; i < 8; i++) begin
            #16 dq_o <= d[i*8 +: 8];
        end
        #16 dq_o <= ~d[63:56];
        repeat (GAP) @(negedge ck_o);
    endtask
endmodule

// ==== tb/row_repair_ctrl_tb.sv ====
// Self-checking bench of the soft row repair block
`timescale 1ns/1ps
module row_repair_ctrl_tb;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ck, cs_n, act_n, ack, oe, mode, hit, assoc;
    logic [1:0]  bg, ba;
    logic [3:0]  sel = 0, bk;
    logic [7:0]  adr = 0, mdq, dout;
    logic [17:0] addr, row;
    logic [31:0] wdat = 0, rdat, q;
    int          fails = 0, checks_done = 0, cycles = 0, vld = 0;
    always #2 clk_i = ~clk_i;
    mc_model m (.ck_o(ck), .cs_n_o(cs_n), .act_n_o(act_n), .bg_o(bg), .ba_o(ba), .addr_o(addr), .dq_o(mdq));
    row_repair_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ck_i(ck), .cs_n_i(cs_n), .act_n_i(act_n),
        .bg_i(bg), .ba_i(ba), .addr_i(addr), .dq_i(oe ? dout : mdq), .dq_o(dout), .dq_oe_o(oe),
        .soft_mode_o(mode), .repair_hit_o(hit), .assoc_hit_o(assoc));
    task automatic results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, far above the expected run
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Classic cycle held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    // Normal activate and precharge of the current bank; every bank left idle
    task automatic act(input logic [17:0] r);
        m.cmd(1'b0, bk[3:2], bk[1:0], r);
        m.cmd(1'b1, bk[3:2], bk[1:0], 18'h08000);
    endtask
    task automatic repair(input logic [63:0] d, input bit bad, ok);
        m.cmd(1'b1, 2'h1, 2'h0, 18'h00020); // Hard bit low; sequence commands only, no
        chk({mode, oe, dout}, 32'h3ff);
        for (int k = 0; k < 4; k++) m.cmd(1'b1, 2'h0, 2'h0, {6'h0, ppr_pkg::GUARD_KEYS[bad ? 3 - k : k], 7'h7f});
        chk(oe, 0);
        m.cmd(1'b0, bk[3:2], bk[1:0], row);
        m.wr(bk[3:2], bk[1:0], d);
        m.cmd(1'b1, bk[3:2], bk[1:0], 18'h08000);
        m.cmd(1'b1, 2'h1, 2'h0, 18'h0);
        chk(mode, 0);
        if (!bad && d == 0 && ok) vld |= 1 << bk;
        wb(0, ppr_pkg::REG_SOFT_VLD, 0);
        chk(q, 32'(vld));
        $display("repair test done, bank %0d", bk);
    endtask
    initial begin
        void'($urandom(32'he417));
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        wb(0, ppr_pkg::REG_CTRL, 0);
        chk(q, 32'h10b);
        wb(0, 8'h10, 0);
        chk(q, 0);
        $display("register test done");
        wb(1, ppr_pkg::REG_CTRL, 32'h10b);
        bk = 4'($urandom);
        row = 18'($urandom);
        repair(0, 0, 1);
        act(row);
        chk(hit, 1);
        act(row ^ 18'h1);
        chk({hit, assoc}, 1);
        bk ^= 4'h1;
        repair({$urandom, $urandom} | 64'h1, 0, 1);
        bk ^= 4'h2;
        repair(0, 1, 1);
        bk ^= 4'h4;
        wb(1, ppr_pkg::REG_HARD_AVL, 32'hffff ^ (1 << bk));
        repair(0, 0, 0);
        // Commit and discard stick, row recognised, idle, no misuse; ones clear the sticky bits
        wb(0, ppr_pkg::REG_STATUS, 0);
        chk(q, 32'h138);
        wb(1, ppr_pkg::REG_STATUS, 32'h1f);
        wb(0, ppr_pkg::REG_STATUS, 0);
        chk(q, 32'h120);
        $display("status test done");
        bk ^= 4'h7;
        row ^= 18'h100;
        repair(0, 0, 1);
        act(row ^ 18'h100);
        chk(hit, 0);
        $display("hit test done");
        @(posedge clk_i);
        rst_i <= 1;
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        vld = 0;
        wb(0, ppr_pkg::REG_SOFT_VLD, 0);
        chk(q, 0);
        $display("reset test done");
        // Readout page 2: resource present, soft support switched off
        wb(1, ppr_pkg::REG_CTRL, 32'h00b);
        m.cmd(1'b1, 2'h0, 2'h3, 18'h00006);
        m.cmd(1'b1, 2'h0, 2'h0, 18'h14000);
        repeat (7) @(negedge ck);
        chk({oe, dout}, 32'h1ff);
        @(posedge ck);
        chk({oe, dout}, 32'h100);
        $display("readout test done");
        results();
    end
endmodule
